// ==== test/csbr_host.sv ====
// host model: frames one serial read per go pulse
`timescale 1ns/1ns
`default_nettype none
module csbr_host (
	input  wire logic              go_in,      // frame request
	input  wire logic              sdo_a_in,   // serial data a
	input  wire logic              sdo_b_in,   // serial data b
	output logic                   cs_n_out,   // chip select
	output logic                   sclk_out,   // link clock
	output logic [15:0]            word_a_out, // word a
	output logic [15:0]            word_b_out  // word b
);
	// clock stands still outside frames; msb first
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		word_a_out = 16'h0000;
		word_b_out = 16'h0000;
		forever begin
			@(posedge go_in);
			cs_n_out = 1'b0;
			for (int i = 0; i < 16; i++) begin
				#80;
				word_a_out = {word_a_out[14:0], sdo_a_in};
				word_b_out = {word_b_out[14:0], sdo_b_in};
				sclk_out = 1'b1;
				#80;
				sclk_out = 1'b0;
			end
			cs_n_out = 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== test/csbr_top_bench.sv ====
// self-checking bench for conversion start, busy and read-out
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, v) begin cmp_count++; if ((v) !== (e)) begin error_cnt++; $display("wrong value %s exp %h got %h", n, e, v); end end
module csbr_top_bench;
	logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, hw = 1'b0, burst = 1'b0, ovs = 1'b0;
	logic ser = 1'b0, csp_n = 1'b1, rd_n = 1'b1, go = 1'b0, cs_n;
	logic [2:0] sel = 3'h0;
	logic [15:0] sa = 16'h0000, sb = 16'h0000, ea, eb;
	wire logic busy, oe, soa, sob, soe, csh_n, sclk;
	wire logic [2:0] ch;
	wire logic [15:0] pd, wa, wb;
	int error_cnt = 0, cmp_count = 0, cyc = 0;
	assign cs_n = ser ? csh_n : csp_n;
	always #10 clk = ~clk;
	csbr_top u_csbr_top (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .CLK_EN_IN(1'b1),
		.CONVERSION_START_IN(start), .PAIR_SELECT_IN(sel), .HW_MODE_IN(hw), .BURST_EN_IN(burst),
		.OVERSAMPLE_EN_IN(ovs), .INTERFACE_SELECT_IN(ser), .CS_N_IN(cs_n), .RD_N_IN(rd_n),
		.SCLK_IN(sclk), .SAMPLE_A_IN(sa), .SAMPLE_B_IN(sb), .BUSY_OUT(busy), .CONV_CHANNEL_OUT(ch),
		.PARALLEL_DATA_BUS_OUT(pd), .PARALLEL_DATA_BUS_OE_OUT(oe), .SERIAL_OUT_GROUP_A_OUT(soa),
		.SERIAL_OUT_GROUP_B_OUT(sob), .SERIAL_OE_OUT(soe));
	csbr_host u_csbr_host (.go_in(go), .sdo_a_in(soa), .sdo_b_in(sob), .cs_n_out(csh_n),
		.sclk_out(sclk), .word_a_out(wa), .word_b_out(wb));
	task automatic results();
		if (error_cnt == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end
	// one start edge, a second edge while busy, then count busy length
	task automatic conv(input logic h, input logic [2:0] s, input logic b, input logic o, input int n);
		int k;
		k = 0;
		@(negedge clk);
		hw = h;
		sel = s; // zero in software mode
		burst = b;
		ovs = o;
		ea = {13'h1a5, s};
		eb = {s, 13'h0c3};
		sa = ea;
		sb = eb;
		start = 1'b1;
		while (busy !== 1'b1 && k < 10) begin
			@(negedge clk);
			k++;
		end
		`CHK("busy rise", 1'b1, busy)
		`CHK("channel", (h ? s : 3'h0), ch)
		k = 0;
		while (busy === 1'b1 && k < 200) begin
			@(negedge clk);
			k++;
			start = (k == 3);
		end
		`CHK("busy cycles", csbr_pkg::CONV_CYCLES * n + 1, k)
		`CHK("last channel", 3'((h ? s : 3'h0) + n - 1), ch)
		sa = ~ea;
		sb = ~eb;
		repeat (8) @(negedge clk);
		`CHK("busy refire", 1'b0, busy)
	endtask
	task automatic par_read();
		ser = 1'b0;
		csp_n = 1'b0;
		repeat (6) @(negedge clk);
		`CHK("oe cs only", 1'b0, oe)
		rd_n = 1'b0;
		repeat (6) @(negedge clk);
		`CHK("oe read", 1'b1, oe)
		`CHK("par data", ea, pd)
		csp_n = 1'b1;
		repeat (6) @(negedge clk);
		`CHK("oe released", 1'b0, oe)
		rd_n = 1'b1;
	endtask
	task automatic ser_read();
		ser = 1'b1;
		rd_n = 1'b0;
		repeat (6) @(negedge clk);
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		repeat (5) @(negedge clk);
		`CHK("serial oe", 1'b1, soe)
		`CHK("par oe in serial", 1'b0, oe)
		repeat (134) @(negedge clk);
		`CHK("serial a", ea, wa)
		`CHK("serial b", eb, wb)
		`CHK("serial oe off", 1'b0, soe)
		ser = 1'b0;
		rd_n = 1'b1;
	endtask
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		`CHK("busy idle", 1'b0, busy)
		conv(1'b1, 3'h0, 1'b0, 1'b0, 1);
		par_read();
		conv(1'b1, 3'h1, 1'b0, 1'b0, 1);
		ser_read();
		conv(1'b1, 3'h7, 1'b0, 1'b0, 1);
		par_read();
		conv(1'b0, 3'h0, 1'b1, 1'b0, 4);
		ser_read();
		conv(1'b0, 3'h0, 1'b0, 1'b1, 4);
		par_read();
		results();
	end
endmodule
`default_nettype wire

// ==== verilog/csbr_pkg.sv ====
// package of constants for the conversion start, busy and read-out block
package csbr_pkg;
	localparam int unsigned DATA_W       = 16;
	localparam int unsigned SEL_W        = 3;
	localparam int unsigned SER_BITS     = 16;
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned CONV_TIME_NS = 400;
	localparam int unsigned CONV_CYCLES  = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W        = 8;
	localparam int unsigned CONV_CNT_W   = 6;
	localparam logic [DATA_W-1:0] RESULT_RST = 16'h0000;
	localparam logic [10:0]       SYNC_RST   = 11'h00e;
	localparam logic [4:0]        EDGE_RST   = 5'h0e;
	localparam logic [CNT_W-1:0]  BURST_CONVS = 8'h04;
	typedef enum logic [1:0] {CSBR_IDLE, CSBR_CONV, CSBR_DONE} csbr_state_t;
endpackage

// ==== verilog/csbr_top.sv ====
// conversion start, busy and read-out control
//
// Contract
// - parallel bus driven only while chip select and read strobe are both low.
// - serial transfer framed by chip select; MSB presented on chip select assertion.
// - hardware mode: pair select picks same channel in both groups.
// - busy rises after a conversion start rising edge.
// - busy stays high until all selected channels are converted.
// - on busy fall, new results latch into output registers.
// - conversion start edges while busy are ignored.
// - rising conversion start launches conversion of the selected pair.
// - no burst, no oversampling: one edge converts exactly one pair.
// - burst or oversampling: one edge performs all required conversions.
// - each serial clock rising edge shifts next bit onto both outputs.
// - interface select low is parallel, high is serial.
`timescale 1ns/1ns
`default_nettype none
module csbr_top (
	input  wire logic                           REF_CLK_IN,              // 50 MHz clock
	input  wire logic                           RESET_N_IN,              // async reset, low
	input  wire logic                           CLK_EN_IN,               // clock enable
	input  wire logic                           CONVERSION_START_IN,     // start pin
	input  wire logic [csbr_pkg::SEL_W-1:0]     PAIR_SELECT_IN,          // channel pair select
	input  wire logic                           HW_MODE_IN,              // 1 hardware mode
	input  wire logic                           BURST_EN_IN,             // burst enable
	input  wire logic                           OVERSAMPLE_EN_IN,        // oversampling enable
	input  wire logic                           INTERFACE_SELECT_IN,     // 1 serial, 0 parallel
	input  wire logic                           CS_N_IN,                 // chip select, low
	input  wire logic                           RD_N_IN,                 // read strobe, low
	input  wire logic                           SCLK_IN,                 // serial clock
	input  wire logic [csbr_pkg::DATA_W-1:0]    SAMPLE_A_IN,             // group a converter word
	input  wire logic [csbr_pkg::DATA_W-1:0]    SAMPLE_B_IN,             // group b converter word
	output logic                                BUSY_OUT,                // busy
	output logic [csbr_pkg::SEL_W-1:0]          CONV_CHANNEL_OUT,        // channel under conversion
	output logic [csbr_pkg::DATA_W-1:0]         PARALLEL_DATA_BUS_OUT,   // parallel data
	output logic                                PARALLEL_DATA_BUS_OE_OUT,// parallel drive enable
	output logic                                SERIAL_OUT_GROUP_A_OUT,  // serial data a
	output logic                                SERIAL_OUT_GROUP_B_OUT,  // serial data b
	output logic                                SERIAL_OE_OUT            // serial drive enable
);
	// ****************************************
	// input synchronisers
	// ****************************************
	logic [10:0]                meta_r, sync_r;
	logic [10:0]                meta_nxt, sync_nxt;
	logic [4:0]                 prev_r, prev_nxt;
	logic                       conv_rise, sclk_rise, cs_fall;
	logic                       cs_n_s, rd_n_s, ser_s;
	logic                       hw_s, burst_s, ovs_s;
	logic [csbr_pkg::SEL_W-1:0] sel_s;

	// mode and pair select pins pass the same two stages as the strobes
	always_comb begin
		meta_nxt = {HW_MODE_IN, BURST_EN_IN, OVERSAMPLE_EN_IN, PAIR_SELECT_IN,
			CONVERSION_START_IN, SCLK_IN, CS_N_IN, RD_N_IN, INTERFACE_SELECT_IN};
		sync_nxt = meta_r;
		prev_nxt = sync_r[4:0];
	end

	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			meta_r <= csbr_pkg::SYNC_RST;
			sync_r <= csbr_pkg::SYNC_RST;
			prev_r <= csbr_pkg::EDGE_RST;
		end else if (CLK_EN_IN) begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
			prev_r <= prev_nxt;
		end
	end

	assign conv_rise = sync_r[4] & ~prev_r[4];
	assign sclk_rise = sync_r[3] & ~prev_r[3];
	assign cs_fall   = ~sync_r[2] & prev_r[2];
	assign cs_n_s    = sync_r[2];
	assign rd_n_s    = sync_r[1];
	assign ser_s     = sync_r[0];
	assign sel_s     = sync_r[7:5];
	assign ovs_s     = sync_r[8];
	assign burst_s   = sync_r[9];
	assign hw_s      = sync_r[10];

	// ****************************************
	// conversion sequencer
	// ****************************************
	csbr_pkg::csbr_state_t               state_r, state_nxt;
	logic [csbr_pkg::CONV_CNT_W-1:0]     tick_r, tick_nxt;
	logic [csbr_pkg::CNT_W-1:0]          left_r, left_nxt;
	logic [csbr_pkg::SEL_W-1:0]          chan_r, chan_nxt;
	logic                                busy_r, busy_nxt;
	logic [csbr_pkg::DATA_W-1:0]         res_a_r, res_a_nxt, res_b_r, res_b_nxt;

	always_comb begin
		state_nxt = state_r;
		tick_nxt  = tick_r;
		left_nxt  = left_r;
		chan_nxt  = chan_r;
		busy_nxt  = busy_r;
		res_a_nxt = res_a_r;
		res_b_nxt = res_b_r;
		case (state_r)
			csbr_pkg::CSBR_IDLE: begin
				if (conv_rise) begin
					state_nxt = csbr_pkg::CSBR_CONV;
					busy_nxt  = 1'b1;
					tick_nxt  = csbr_pkg::CONV_CNT_W'(csbr_pkg::CONV_CYCLES - 1);
					chan_nxt  = hw_s ? sel_s : 3'h0;
					left_nxt  = (burst_s | ovs_s) ?
						csbr_pkg::BURST_CONVS - 8'h01 : 8'h00;
				end
			end
			csbr_pkg::CSBR_CONV: begin
				// edges here are simply not looked at
				if (tick_r != '0) begin
					tick_nxt = tick_r - 6'h01;
				end else if (left_r != '0) begin
					left_nxt = left_r - 8'h01;
					chan_nxt = chan_r + 3'h1;
					tick_nxt = csbr_pkg::CONV_CNT_W'(csbr_pkg::CONV_CYCLES - 1);
				end else begin
					state_nxt = csbr_pkg::CSBR_DONE;
				end
			end
			csbr_pkg::CSBR_DONE: begin
				busy_nxt  = 1'b0;
				res_a_nxt = SAMPLE_A_IN;
				res_b_nxt = SAMPLE_B_IN;
				state_nxt = csbr_pkg::CSBR_IDLE;
			end
			default: state_nxt = csbr_pkg::CSBR_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			state_r <= csbr_pkg::CSBR_IDLE;
			tick_r  <= '0;
			left_r  <= '0;
			chan_r  <= '0;
			busy_r  <= 1'b0;
			res_a_r <= csbr_pkg::RESULT_RST;
			res_b_r <= csbr_pkg::RESULT_RST;
		end else if (CLK_EN_IN) begin
			state_r <= state_nxt;
			tick_r  <= tick_nxt;
			left_r  <= left_nxt;
			chan_r  <= chan_nxt;
			busy_r  <= busy_nxt;
			res_a_r <= res_a_nxt;
			res_b_r <= res_b_nxt;
		end
	end

	assign BUSY_OUT         = busy_r;
	assign CONV_CHANNEL_OUT = chan_r;

	// ****************************************
	// read-out, parallel and serial
	// ****************************************
	logic [csbr_pkg::DATA_W-1:0] pbus_r, pbus_nxt, sh_a_r, sh_a_nxt, sh_b_r, sh_b_nxt;
	logic                        poe_r, poe_nxt, soe_r, soe_nxt;

	always_comb begin
		poe_nxt  = ~ser_s & ~cs_n_s & ~rd_n_s;
		pbus_nxt = poe_nxt ? res_a_r : pbus_r;
		soe_nxt  = ser_s & ~cs_n_s;
		sh_a_nxt = sh_a_r;
		sh_b_nxt = sh_b_r;
		if (ser_s && cs_fall) begin
			sh_a_nxt = res_a_r;
			sh_b_nxt = res_b_r;
		end else if (soe_r && sclk_rise) begin
			sh_a_nxt = {sh_a_r[csbr_pkg::DATA_W-2:0], 1'b0};
			sh_b_nxt = {sh_b_r[csbr_pkg::DATA_W-2:0], 1'b0};
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			pbus_r <= '0;
			poe_r  <= 1'b0;
			soe_r  <= 1'b0;
			sh_a_r <= '0;
			sh_b_r <= '0;
		end else if (CLK_EN_IN) begin
			pbus_r <= pbus_nxt;
			poe_r  <= poe_nxt;
			soe_r  <= soe_nxt;
			sh_a_r <= sh_a_nxt;
			sh_b_r <= sh_b_nxt;
		end
	end

	assign PARALLEL_DATA_BUS_OUT    = pbus_r;
	assign PARALLEL_DATA_BUS_OE_OUT = poe_r;
	assign SERIAL_OUT_GROUP_A_OUT   = sh_a_r[csbr_pkg::DATA_W-1];
	assign SERIAL_OUT_GROUP_B_OUT   = sh_b_r[csbr_pkg::DATA_W-1];
	assign SERIAL_OE_OUT            = soe_r;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!RESET_N_IN || !CLK_EN_IN);

	a_busy_rises: assert property (state_r == csbr_pkg::CSBR_IDLE && conv_rise |=> busy_r)
		else $error("busy did not rise after start");
	a_busy_holds: assert property ($rose(busy_r) |-> busy_r [*8])
		else $error("busy fell early");
	a_latch_on_fall: assert property ($fell(busy_r) |-> res_a_r == $past(SAMPLE_A_IN))
		else $error("result not latched at busy fall");
	a_ignore_busy: assert property (busy_r && state_r == csbr_pkg::CSBR_CONV && tick_r > 1
		|=> busy_r)
		else $error("start edge disturbed busy");
	a_par_oe: assert property (poe_r |-> !$past(ser_s) && !$past(cs_n_s) && !$past(rd_n_s))
		else $error("parallel bus driven without strobes");
	a_hw_chan: assert property (state_r == csbr_pkg::CSBR_IDLE && conv_rise && hw_s
		|=> chan_r == $past(sel_s))
		else $error("wrong channel pair");
	a_serial_msb: assert property (ser_s && cs_fall |=> sh_a_r == $past(res_a_r))
		else $error("msb not presented");
	a_single_pair: assert property (state_r == csbr_pkg::CSBR_IDLE && conv_rise
		&& !burst_s && !ovs_s |=> left_r == 8'h00)
		else $error("extra conversions queued");
	a_shift: assert property (soe_r && sclk_rise && !cs_fall |=> sh_b_r[15:1] == $past(sh_b_r[14:0]))
		else $error("serial shift wrong");
	c_conv:   cover property ($fell(busy_r));
	c_burst:  cover property (busy_r && left_r == 8'h01);
	c_par:    cover property (poe_r);
	c_serial: cover property (soe_r && sclk_rise);
endmodule
`default_nettype wire
